// >>> src/rca_calendar.sv
/*
 * Weekday, month and year counters, access hold of the time chain, one pending
 * tick, seconds match and the match flag, all behind an AXI4-Lite slave.
 * Assumes the seconds..days chain and other match fields sit outside and advance
 * on tickOut; inputs are synchronous to clk.
 */
`timescale 1ns/1ps
// Operation
// - Weekday in bits 2:0, upper bits zero
// - Code 000 is Sunday, 001 Monday
// - Month BCD 1..12, tens in bit 4
// - Unimplemented bits read as zero
// - Year BCD 0..99, tens bits 7:4
// - Calendar and match values survive reset
// - Counting advances on 1 Hz tick
// - Freeze time counting during host access
// - Release and serve pending tick after access
// - Only one pending tick is held
// - Compare enabled fields against current time
// - Seconds disable bit 7, resets to one
// - Seconds match value BCD 0..59
// - Flag sets on first match, sticky
// - Year divisible by four gives Feb 29
module rca_calendar
   import rca_pkg::*;
#(
   parameter int ADDR_W = 8 // AXI address width.
)
(
   input wire logic clk, // 125 MHz clock.
   input wire logic rst, // Synchronous reset, active high.
   input wire logic tick1Hz, // One-cycle 1 Hz tick.
   input wire rca_ctx_t ctx, // Context from neighbouring counters.
   output logic tickOut, // Serviced tick to the counter chain.
   output logic leapYear, // February has a 29th day.
   output logic [4:0] monthNow, // Current month, BCD.
   output logic matchFlag, // Sticky match flag.
   output logic irq, // Level interrupt.
   input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address.
   input wire logic s_axi_awvalid, // Write address valid.
   output logic s_axi_awready, // Write address ready.
   input wire logic [31:0] s_axi_wdata, // Write data.
   input wire logic [3:0] s_axi_wstrb, // Byte strobes.
   input wire logic s_axi_wvalid, // Write data valid.
   output logic s_axi_wready, // Write data ready.
   output logic [1:0] s_axi_bresp, // Write response.
   output logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address.
   input wire logic s_axi_arvalid, // Read address valid.
   output logic s_axi_arready, // Read address ready.
   output logic [31:0] s_axi_rdata, // Read data.
   output logic [1:0] s_axi_rresp, // Read response.
   output logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready // Read data ready.
);
   // ************************************************************
   // Elaboration check.
   // ************************************************************
   // The register index is taken from address bits 7:2, so eight address bits are needed.
   if (ADDR_W < 8 || ADDR_W > 32)
   begin : g_bad_addr
      $error("rca_calendar: ADDR_W must be 8 to 32.");
   end

   // ************************************************************
   // Functions.
   // ************************************************************
   // Advance a two-digit BCD value; the tens wrap is handled by the caller.
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      logic [7:0] r;
      r = v;
      if (v[3:0] == 4'h9)
      begin
         r = {v[7:4] + 4'h1, 4'h0};
      end
      else
      begin
         r = {v[7:4], v[3:0] + 4'h1};
      end
      return r;
   endfunction : bcd_inc

   // Year divisible by four: even tens with units 0/4/8, odd tens with 2/6.
   function automatic logic leap_of(input logic [7:0] y);
      logic r;
      r = 1'b0;
      if (y[4] == 1'b0)
      begin
         r = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
      end
      else
      begin
         r = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      end
      return r;
   endfunction : leap_of

   // ************************************************************
   // State and combinational helpers.
   // ************************************************************
   rca_state_t s; // Registered state.
   rca_state_t next_s; // Next state.
   logic busy; // A host access is in progress.
   logic blocked; // Time chain frozen.
   logic wrDo; // Write performed this cycle.
   logic [5:0] wrIdx; // Index of that write.
   logic [5:0] arIdx; // Index of the incoming read.
   logic secMatch; // Seconds comparison result.
   logic alarmMatch; // All enabled comparisons match.
   logic [7:0] monthInc; // Month plus one in BCD, before the tens cut.

   // Bus access counts as an access, so a read of the calendar never sees a carry.
   assign busy = s.awSeen || s.wSeen || s.bValid || s.rValid || s_axi_arvalid;
   assign blocked = s.hold || busy;
   // A held tick and a fresh one merge into one serviced step.
   assign tickOut = !blocked && (tick1Hz || s.pending);
   assign leapYear = leap_of(s.year);
   assign monthNow = s.month;
   assign matchFlag = s.stat[ST_MATCH];
   assign irq = |(s.stat & s.irqEn);
   assign wrDo = s.awSeen && s.wSeen && !s.bValid;
   assign wrIdx = s.awIdx;
   assign arIdx = s_axi_araddr[7:2];
   // The month reuses the year incrementer; its tens digit fits in bit 4.
   assign monthInc = bcd_inc({3'h0, s.month});
   assign secMatch = s.secVal == ctx.secondsNow;
   // At least one field must be enabled; disabled ones are ignored.
   assign alarmMatch = (!s.secDis || ctx.otherAnyEnabled) && (s.secDis || secMatch) && ctx.otherMatch;

   assign s_axi_awready = !s.awSeen && !s.bValid;
   assign s_axi_wready = !s.wSeen && !s.bValid;
   assign s_axi_bvalid = s.bValid;
   assign s_axi_bresp = s.bResp;
   assign s_axi_arready = !s.rValid;
   assign s_axi_rvalid = s.rValid;
   assign s_axi_rresp = s.rResp;
   assign s_axi_rdata = {24'h000000, s.rData};

   // ************************************************************
   // Next-state logic.
   // ************************************************************
   // Order inside: counters, then host writes so that software wins over a step.
   always_comb
   begin
      next_s = s;
      // Hold one step while blocked; a second tick is lost and flagged.
      if (blocked && tick1Hz)
      begin
         next_s.pending = 1'b1;
         if (s.pending)
         begin
            next_s.stat[ST_LOST] = 1'b1;
         end
      end
      else if (!blocked)
      begin
         next_s.pending = 1'b0;
      end
      // The compare runs once the outside seconds have taken the step.
      next_s.evalDue = tickOut;
      // Calendar carries from the day counter; Sunday is code 0.
      if (ctx.dayCarry)
      begin
         next_s.weekday = (s.weekday == WDAY_LAST) ? 3'h0 : s.weekday + 3'h1;
      end
      if (ctx.monthCarry)
      begin
         if (s.month == MONTH_DEC)
         begin
            next_s.month = MONTH_JAN;
            next_s.year = (s.year == 8'h99) ? 8'h00 : bcd_inc(s.year);
         end
         else
         begin
            next_s.month = monthInc[4:0];
         end
      end
      // Write channel: address and data taken in either order.
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_s.awSeen = 1'b1;
         next_s.awIdx = s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_s.wSeen = 1'b1;
         next_s.wData = s_axi_wdata[7:0];
         next_s.wLane = s_axi_wstrb[0];
      end
      if (wrDo)
      begin
         next_s.awSeen = 1'b0;
         next_s.wSeen = 1'b0;
         next_s.bValid = 1'b1;
         next_s.bResp = RESP_OKAY;
         unique case (wrIdx)
            IDX_WEEKDAY: if (s.wLane) next_s.weekday = s.wData[2:0];
            IDX_MONTH: if (s.wLane) next_s.month = s.wData[4:0];
            IDX_YEAR: if (s.wLane) next_s.year = s.wData;
            IDX_SECMATCH:
            begin
               if (s.wLane)
               begin
                  next_s.secDis = s.wData[SEC_DIS_BIT];
                  next_s.secVal = s.wData[6:0];
               end
            end
            IDX_HOLD: if (s.wLane) next_s.hold = s.wData[0];
            IDX_IRQ_STAT: next_s.bResp = RESP_OKAY;
            IDX_IRQ_EN: if (s.wLane) next_s.irqEn = s.wData[1:0];
            IDX_IRQ_CLR: if (s.wLane) next_s.stat = next_s.stat & ~s.wData[1:0];
            default: next_s.bResp = RESP_SLVERR;
         endcase
      end
      if (s.bValid && s_axi_bready)
      begin
         next_s.bValid = 1'b0;
      end
      // Set after clear so an event in the clearing cycle is kept.
      if (s.evalDue && alarmMatch)
      begin
         next_s.stat[ST_MATCH] = 1'b1;
      end
      if (blocked && tick1Hz && s.pending)
      begin
         next_s.stat[ST_LOST] = 1'b1;
      end
      // Read channel; unimplemented bits return zero.
      if (s.rValid && s_axi_rready)
      begin
         next_s.rValid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
         next_s.rValid = 1'b1;
         next_s.rIdx = arIdx;
         next_s.rResp = RESP_OKAY;
         next_s.rData = 8'h00;
         unique case (arIdx)
            IDX_WEEKDAY: next_s.rData = {5'h00, s.weekday};
            IDX_MONTH: next_s.rData = {3'h0, s.month};
            IDX_YEAR: next_s.rData = s.year;
            IDX_SECMATCH: next_s.rData = {s.secDis, s.secVal};
            IDX_HOLD: next_s.rData = {7'h00, s.hold};
            IDX_IRQ_STAT: next_s.rData = {6'h00, s.stat};
            IDX_IRQ_EN: next_s.rData = {6'h00, s.irqEn};
            IDX_IRQ_CLR: next_s.rData = 8'h00;
            default: next_s.rResp = RESP_SLVERR;
         endcase
      end
      // Reset touches control only; calendar and match values are kept.
      if (rst)
      begin
         next_s.secDis = SEC_DIS_RST;
         next_s.hold = 1'b0;
         next_s.pending = 1'b0;
         next_s.evalDue = 1'b0;
         next_s.stat = 2'h0;
         next_s.irqEn = 2'h0;
         next_s.awSeen = 1'b0;
         next_s.awIdx = 6'h00;
         next_s.wSeen = 1'b0;
         next_s.wData = 8'h00;
         next_s.wLane = 1'b0;
         next_s.bValid = 1'b0;
         next_s.bResp = RESP_OKAY;
         next_s.rValid = 1'b0;
         next_s.rIdx = 6'h00;
         next_s.rData = 8'h00;
         next_s.rResp = RESP_OKAY;
      end
   end

   // Single state register.
   always_ff @(posedge clk)
   begin
      s <= next_s;
   end

   // ************************************************************
   // Assertions.
   // ************************************************************
   property p_freeze;
      @(posedge clk) disable iff (rst) blocked |-> !tickOut;
   endproperty
   a_freeze: assert property (p_freeze) else $error("Tick passed while blocked.");

   property p_serve;
      @(posedge clk) disable iff (rst) (s.pending && !blocked) |-> tickOut ##1 !s.pending;
   endproperty
   a_serve: assert property (p_serve) else $error("Pending tick not served.");

   property p_one_pending;
      @(posedge clk) disable iff (rst) (blocked && tick1Hz) |=> s.pending;
   endproperty
   a_one_pending: assert property (p_one_pending) else $error("Held tick not stored.");

   property p_flag;
      @(posedge clk) disable iff (rst) (tickOut ##1 alarmMatch) |=> matchFlag;
   endproperty
   a_flag: assert property (p_flag) else $error("Match flag not set.");

   property p_disable_rst;
      @(posedge clk) disable iff (rst) $past(rst) |-> s.secDis && !matchFlag;
   endproperty
   a_disable_rst: assert property (p_disable_rst) else $error("Disable bit not one after reset.");

   property p_wday_read;
      @(posedge clk) disable iff (rst) (s.rValid && s.rIdx == IDX_WEEKDAY) |-> s_axi_rdata[7:3] == 5'h00;
   endproperty
   a_wday_read: assert property (p_wday_read) else $error("Weekday upper bits not zero.");

   property p_leap;
      @(posedge clk) disable iff (rst) (s.year == 8'h00 || s.year == 8'h24) |-> leapYear;
   endproperty
   a_leap: assert property (p_leap) else $error("Leap year missed.");

   property p_wday_wrap;
      @(posedge clk) disable iff (rst)
         (ctx.dayCarry && s.weekday == WDAY_LAST && !(wrDo && wrIdx == IDX_WEEKDAY)) |=> s.weekday == 3'h0;
   endproperty
   a_wday_wrap: assert property (p_wday_wrap) else $error("Weekday did not wrap.");

   property p_year_wrap;
      @(posedge clk) disable iff (rst)
         (ctx.monthCarry && s.month == MONTH_DEC && s.year == 8'h99 && !wrDo)
         |=> s.month == MONTH_JAN && s.year == 8'h00;
   endproperty
   a_year_wrap: assert property (p_year_wrap) else $error("Year did not wrap.");

   property p_pass;
      @(posedge clk) disable iff (rst) (!blocked && tick1Hz) |-> tickOut;
   endproperty
   a_pass: assert property (p_pass) else $error("Unblocked tick not passed on.");

   property p_lost;
      @(posedge clk) disable iff (rst) (blocked && tick1Hz && s.pending) |=> s.stat[ST_LOST];
   endproperty
   a_lost: assert property (p_lost) else $error("Lost tick not flagged.");

   property p_all_off;
      @(posedge clk) disable iff (rst) (s.secDis && !ctx.otherAnyEnabled) |=> !$rose(matchFlag);
   endproperty
   a_all_off: assert property (p_all_off) else $error("Flag set with every field disabled.");

   property p_month_read;
      @(posedge clk) disable iff (rst) (s.rValid && s.rIdx == IDX_MONTH) |-> s_axi_rdata[7:5] == 3'h0;
   endproperty
   a_month_read: assert property (p_month_read) else $error("Month upper bits not zero.");

   // Carry steps that the random calendar stimulus reaches now and then.
   property p_month_tens;
      @(posedge clk) disable iff (rst)
         (ctx.monthCarry && s.month == 5'h09 && !wrDo) |=> s.month == 5'h10;
   endproperty
   a_month_tens: assert property (p_month_tens) else $error("September did not step to October.");

   property p_sunday;
      @(posedge clk) disable iff (rst)
         (ctx.dayCarry && s.weekday == 3'h0 && !(wrDo && wrIdx == IDX_WEEKDAY)) |=> s.weekday == 3'h1;
   endproperty
   a_sunday: assert property (p_sunday) else $error("Sunday did not step to Monday.");

   property p_year_tens;
      @(posedge clk) disable iff (rst)
         (ctx.monthCarry && s.month == MONTH_DEC && s.year == 8'h09 && !wrDo) |=> s.year == 8'h10;
   endproperty
   a_year_tens: assert property (p_year_tens) else $error("Year units did not carry into tens.");
endmodule : rca_calendar

// >>> src/rca_pkg.sv
/*
 * Shared constants and types of the calendar, access-hold and seconds-match block.
 * Assumes an AXI4-Lite master with 32-bit data and a 1 Hz tick synchronous to clk.
 */
package rca_pkg;
   // ************************************************************
   // Register indices; the byte address is four times the index.
   // ************************************************************
   localparam logic [5:0] IDX_WEEKDAY = 6'h07; // Weekday counter.
   localparam logic [5:0] IDX_MONTH = 6'h08; // Month counter.
   localparam logic [5:0] IDX_YEAR = 6'h09; // Year counter.
   localparam logic [5:0] IDX_SECMATCH = 6'h0A; // Seconds match setting.
   localparam logic [5:0] IDX_HOLD = 6'h10; // Access hold control.
   localparam logic [5:0] IDX_IRQ_STAT = 6'h11; // Sticky event status.
   localparam logic [5:0] IDX_IRQ_EN = 6'h12; // Event enable.
   localparam logic [5:0] IDX_IRQ_CLR = 6'h13; // Write-one-to-clear.
   // ************************************************************
   // Field positions, reset values and codes.
   // ************************************************************
   localparam int SEC_DIS_BIT = 7; // Seconds match disable bit.
   localparam int ST_MATCH = 0; // Status bit: match flag.
   localparam int ST_LOST = 1; // Status bit: tick lost while held.
   localparam logic SEC_DIS_RST = 1'b1; // Disable bit after reset.
   localparam logic [2:0] WDAY_LAST = 3'h6; // Saturday code.
   localparam logic [4:0] MONTH_DEC = 5'h12; // December in BCD.
   localparam logic [4:0] MONTH_JAN = 5'h01; // January in BCD.
   localparam logic [1:0] RESP_OKAY = 2'h0; // AXI OKAY.
   localparam logic [1:0] RESP_SLVERR = 2'h2; // AXI SLVERR.

   // Calendar and match context supplied by the neighbouring counters.
   typedef struct packed {
      logic dayCarry; // Pulse: day counter rolled over.
      logic monthCarry; // Pulse: last day of month rolled over.
      logic [6:0] secondsNow; // Current seconds, BCD.
      logic otherMatch; // All other enabled fields match.
      logic otherAnyEnabled; // Any other field enabled.
   } rca_ctx_t;

   // Whole state of the block.
   typedef struct packed {
      logic [2:0] weekday;
      logic [4:0] month;
      logic [7:0] year;
      logic secDis;
      logic [6:0] secVal;
      logic hold;
      logic pending;
      logic evalDue;
      logic [1:0] stat;
      logic [1:0] irqEn;
      logic awSeen;
      logic [5:0] awIdx;
      logic wSeen;
      logic [7:0] wData;
      logic wLane;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [5:0] rIdx;
      logic [7:0] rData;
      logic [1:0] rResp;
   } rca_state_t;
endpackage : rca_pkg

// >>> verification/rca_chain_model.sv
/*
 * Behavioural model of the seconds-to-days chain and the other match fields.
 * Assumes tickOut is a one-cycle pulse on clk; the bench steers the carries.
 */
`timescale 1ns/1ps
module rca_chain_model
   import rca_pkg::*;
(
   input wire logic clk, // 125 MHz clock.
   input wire logic tickOut, // Serviced tick from the calendar.
   input wire logic dayEnd, // The next tick ends the day.
   input wire logic monthEnd, // The next tick ends the month.
   input wire logic othMatch, // Other enabled fields match.
   input wire logic othEn, // Some other field is enabled.
   output rca_ctx_t ctx // Context to the calendar.
);
   logic [6:0] secs = 7'h00; // Seconds in BCD; no reset, like the real chain.

   // Carries only ride on a serviced tick, never on a raw one.
   always_comb
   begin
      ctx.dayCarry = tickOut & dayEnd;
      ctx.monthCarry = tickOut & dayEnd & monthEnd;
      ctx.secondsNow = secs;
      ctx.otherMatch = othMatch;
      ctx.otherAnyEnabled = othEn;
   end

   // Seconds advance in BCD once per serviced tick and wrap after 59.
   always @(posedge clk)
   begin
      if (tickOut === 1'b1)
      begin
         if (secs == 7'h59)
            secs <= 7'h00;
         else if (secs[3:0] == 4'h9)
            secs <= {secs[6:4] + 3'h1, 4'h0};
         else
            secs <= secs + 7'h01;
      end
   end
endmodule : rca_chain_model

// >>> verification/rca_calendar_tb_top.sv
/*
 * Self-checking bench of the calendar block with an integer reference model.
 * Assumes the chain model beside it and an AXI4-Lite master written here.
 */
`timescale 1ns/1ps
module rca_calendar_tb_top
   import rca_pkg::*;
;
   logic clk, rst = 1'b1, tick = 1'b0, dayEnd = 1'b0, monthEnd = 1'b0, othMatch = 1'b1, othEn = 1'b0;
   logic tickOut, leapYear, matchFlag, irq;
   logic [4:0] monthNow;
   rca_ctx_t ctx;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   logic [7:0] tgt; // Seconds value the match is armed for.
   logic [3:0] strb = 4'hF; // Write strobes; lane 0 carries the register byte.
   int nMismatch = 0, totalChecks = 0, nOut = 0, n0, s, mW, mM, mY;
   bit dE, mE;

   rca_calendar dut (.clk(clk), .rst(rst), .tick1Hz(tick), .ctx(ctx), .tickOut(tickOut), .leapYear(leapYear),
      .monthNow(monthNow), .matchFlag(matchFlag), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   rca_chain_model chain (.clk(clk), .tickOut(tickOut), .dayEnd(dayEnd), .monthEnd(monthEnd),
      .othMatch(othMatch), .othEn(othEn), .ctx(ctx));

   // Free-running 8 ns clock.
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Serviced ticks are counted so that held and lost ticks show up.
   always @(posedge clk)
   begin
      if (tickOut === 1'b1)
         nOut <= nOut + 1;
   end

   // ************************************************************
   // Comparison, bus and stimulus tasks.
   // ************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp)
      begin
         nMismatch++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   function automatic logic [7:0] bcd(input int v);
      return 8'(((v / 10) << 4) | (v % 10));
   endfunction : bcd

   // One write; both halves offered together, each released once taken.
   task automatic wr(input logic [5:0] idx, input logic [7:0] v);
      @(posedge clk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      check({30'h0, bresp}, {30'h0, RESP_OKAY});
   endtask : wr

   task automatic rd(input logic [5:0] idx);
      @(posedge clk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arready)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd

   task automatic rchk(input logic [5:0] idx, input logic [7:0] e);
      rd(idx);
      check(d, {24'h0, e});
      check({30'h0, r}, {30'h0, RESP_OKAY});
   endtask : rchk

   // A one-cycle tick while the bus is idle; carries drop afterwards.
   task automatic pulse;
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      dayEnd <= 1'b0;
      monthEnd <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : pulse

   task automatic final_report;
      $display("checks %0d mismatches %0d", totalChecks, nMismatch);
      if (nMismatch == 0 && totalChecks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : final_report

   // A hung handshake must not stall the run forever.
   initial
   begin
      repeat (20000) @(posedge clk);
      nMismatch++;
      final_report();
   end

   // ************************************************************
   // Main sequence.
   // ************************************************************
   initial
   begin
      void'($urandom(74189));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(IDX_SECMATCH);
      check({31'h0, d[SEC_DIS_BIT]}, 32'h1);
      check({31'h0, irq}, 32'h0);
      check({31'h0, matchFlag}, 32'h0);
      rd(6'h20);
      check({30'h0, r}, {30'h0, RESP_SLVERR});
      check(d, 32'h0);
      // Calendar carries; the first pass hits every wrap at once.
      for (int i = 0; i < 8; i++)
      begin
         mW = (i == 0) ? 6 : $urandom % 7;
         mM = (i == 0) ? 12 : 1 + $urandom % 12;
         mY = (i == 0) ? 99 : $urandom % 100;
         dE = (i == 0) || ($urandom % 2);
         mE = dE && ((i == 0) || ($urandom % 2));
         wr(IDX_WEEKDAY, (8'($urandom) & 8'hF8) | 8'(mW));
         wr(IDX_MONTH, 8'hE0 | bcd(mM));
         wr(IDX_YEAR, bcd(mY));
         dayEnd <= dE;
         monthEnd <= mE;
         pulse();
         mW = dE ? (mW + 1) % 7 : mW;
         mY = (mE && mM == 12) ? (mY + 1) % 100 : mY;
         mM = mE ? ((mM == 12) ? 1 : mM + 1) : mM;
         rchk(IDX_WEEKDAY, 8'(mW));
         rchk(IDX_MONTH, bcd(mM));
         rchk(IDX_YEAR, bcd(mY));
         check({31'h0, leapYear}, {31'h0, mY % 4 == 0});
         check({27'h0, monthNow}, {24'h0, bcd(mM)});
      end
      // With lane 0 off a write must leave the weekday alone.
      strb <= 4'hE;
      wr(IDX_WEEKDAY, 8'($urandom % 7));
      strb <= 4'hF;
      rchk(IDX_WEEKDAY, 8'(mW));
      // Hold the chain: one tick is kept, the next is lost.
      wr(IDX_HOLD, 8'h01);
      n0 = nOut;
      pulse();
      pulse();
      check(nOut, n0);
      rchk(IDX_IRQ_STAT, 8'h02);
      wr(IDX_HOLD, 8'h00);
      repeat (3) @(posedge clk);
      check(nOut, n0 + 1);
      wr(IDX_IRQ_CLR, 8'h03);
      rchk(IDX_IRQ_STAT, 8'h00);
      // Arm the seconds match for the next second with the interrupt masked.
      othMatch <= 1'b1;
      s = ctx.secondsNow[6:4] * 10 + ctx.secondsNow[3:0];
      tgt = bcd((s + 1) % 60);
      wr(IDX_SECMATCH, tgt);
      rchk(IDX_SECMATCH, tgt);
      pulse();
      check({31'h0, matchFlag}, 32'h1);
      check({31'h0, irq}, 32'h0);
      rchk(IDX_IRQ_STAT, 8'h01);
      // The status register is read-only: a write must not clear the flag.
      wr(IDX_IRQ_STAT, 8'h00);
      rchk(IDX_IRQ_STAT, 8'h01);
      wr(IDX_IRQ_EN, 8'h01);
      check({31'h0, irq}, 32'h1);
      wr(IDX_IRQ_CLR, 8'h01);
      check({31'h0, irq}, 32'h0);
      pulse();
      check({31'h0, matchFlag}, 32'h0);
      // A reset in mid-run keeps the calendar and the match value.
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rchk(IDX_WEEKDAY, 8'(mW));
      rchk(IDX_SECMATCH, 8'h80 | tgt);
      final_report();
   end
endmodule : rca_calendar_tb_top
